// File: design/fault_tolerant_can_mode_control.sv
// Mode machine, failure handling and flags of the fault tolerant CAN PHY
//
// What this block does
// RL1 - Normal mode: detect failures, pick transmission mode
// RL2 - Failures 1,2,5,6a keep differential path
// RL3 - Single-wire entry and exit after delays
// RL4 - Failures 3,3a,4,6,7 disable wire stage
// RL5 - Fault flag low while failure present in normal mode
// RL6 - Remote wake: five dominant bits, either wire
// RL7 - Local wake on either edge, held
// RL8 - Three low-power modes plus go-to-sleep
// RL9 - Sleep: inhibit floats, low wire biased
// RL10 - Standby as sleep, inhibit driven high
// RL11 - Power-on standby shows power-on flag
// RL12 - Wake-up request drives inhibit high
// RL13 - Low battery drives inhibit high too
// RL14 - Host reads wake, then selects normal
// RL15 - Wire failures watched in low power
// RL16 - Go-to-sleep holds inhibit, then sleeps
// RL17 - Wake beats go-to-sleep, inhibit stays
// RL18 - Low logic supply forces pins low
// RL19 - Low battery forces low-power mode
// RL20 - Power-up sets flag, normal clears it
// RL21 - Over-temperature disables drivers, flags fault in normal mode
// RL22 - Timer stops permanent dominant transmit
// RL23 - Transmit time-out after 0.75 ms
// RL24 - Host holds go-to-sleep setting long enough
// RL25 - Wake input debounced 7 us minimum
// RL26 - Pin pair decoding of the modes
`timescale 1ns/1ps
module fault_tolerant_can_mode_control #(
  parameter ft_can_pkg::cnt_t TX_TIMEOUT_CYC =
    ft_can_pkg::TX_TIMEOUT_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic standby_n,
  input wire logic enable,
  input wire logic tx_data_in,
  input wire logic wakeInput,
  input wire logic canHighDominant,
  input wire logic canLowDominant,
  input wire logic diffDominant,
  input wire logic minorFailure,
  input wire logic highWireFailure,
  input wire logic lowWireFailure,
  input wire logic logicSupplyLow,
  input wire logic batteryLow,
  input wire logic overTemp,
  output logic rx_data_out,
  output logic fault_flag_n,
  output logic regulator_inhibit,
  output logic regulatorInhibitOe,
  output logic canHighDrive,
  output logic canLowDrive,
  output logic high_wire_termination,
  output logic low_wire_termination,
  output logic lowWireToBattery,
  output logic singleWireMode,
  output ft_can_pkg::mode_t modeState
);
  import ft_can_pkg::*;

  // True for every mode other than normal
  function automatic logic isLowPower(input mode_t m);
    isLowPower = (m != MODE_NORMAL);
  endfunction : isLowPower

  mode_t stateQ;
  mode_t stateD;
  cnt_t goSleepCntQ;
  logic goSleepDone;
  logic wakeQ;
  logic poFlagQ;
  logic stbEff;
  logic enEff;
  logic lowPower;
  logic inNormal;
  logic highFail;
  logic lowFail;
  logic wakeLevel;
  logic wakeEdge;
  logic busDominant;
  logic remoteWake;
  logic txTimeout;
  logic wakeSet;
  logic failAny;
  logic txActive;

  // Fail-safe forcing of the mode pins on missing supplies
  assign stbEff = standby_n && !logicSupplyLow && !batteryLow; // RL18 RL19
  assign enEff = enable && !logicSupplyLow && !batteryLow; // RL18 RL19
  assign lowPower = isLowPower(stateQ);
  assign inNormal = !isLowPower(stateQ);

  // Wire failures filtered in every mode, so shorts that draw current
  // are still isolated while asleep
  level_filter #(
    .LIMIT(FAIL_DELAY_CYC)
  ) highFailFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .rawIn(highWireFailure), // RL3 RL15
    .filtOut(highFail),
    .edgePulse()
  );

  level_filter #(
    .LIMIT(FAIL_DELAY_CYC)
  ) lowFailFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .rawIn(lowWireFailure), // RL3 RL15
    .filtOut(lowFail),
    .edgePulse()
  );

  // Local wake input, both edges after debounce
  level_filter #(
    .LIMIT(WAKE_DEBOUNCE_CYC)
  ) wakeFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .rawIn(wakeInput), // RL7 RL25
    .filtOut(wakeLevel),
    .edgePulse(wakeEdge)
  );

  // Remote wake: either wire dominant, so one dead wire still wakes
  assign busDominant = canHighDominant || canLowDominant; // RL6

  dominant_timer #(
    .LIMIT(REMOTE_WAKE_CYC)
  ) remoteWakeTimer (
    .sys_clk(sys_clk),
    .rst(rst),
    .holdIn(busDominant && lowPower), // RL6
    .expired(remoteWake)
  );

  // Transmit dominant time-out, restarted by any recessive bit
  dominant_timer #(
    .LIMIT(TX_TIMEOUT_CYC)
  ) txTimeoutTimer (
    .sys_clk(sys_clk),
    .rst(rst),
    .holdIn(!tx_data_in && inNormal), // RL22 RL23
    .expired(txTimeout)
  );

  // Wake requests only count outside normal mode
  assign wakeSet = (wakeEdge || remoteWake) && lowPower; // RL6 RL7

  // Go-to-sleep hold time
  assign goSleepDone =
    (goSleepCntQ == cnt_t'(GO_SLEEP_CYC - cnt_t'(1)));

  always_ff @(posedge sys_clk)
  begin
    if (rst || stateQ != MODE_GO_SLEEP)
      goSleepCntQ <= '0;
    else if (!goSleepDone)
      goSleepCntQ <= cnt_t'(goSleepCntQ + cnt_t'(1)); // RL16
  end

  // Mode decoding from the effective pins
  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      MODE_NORMAL:
      begin
        if (stbEff && !enEff)
          stateD = MODE_PON_STBY; // RL26
        else if (!stbEff && enEff)
          stateD = MODE_GO_SLEEP; // RL26
        else if (!stbEff && !enEff)
          stateD = MODE_STANDBY; // RL8
      end
      MODE_PON_STBY:
      begin
        if (stbEff && enEff)
          stateD = MODE_NORMAL;
        else if (!stbEff && enEff)
          stateD = MODE_GO_SLEEP;
        else if (!stbEff && !enEff)
          stateD = MODE_STANDBY;
      end
      MODE_GO_SLEEP:
      begin
        if (stbEff && enEff)
          stateD = MODE_NORMAL;
        else if (stbEff && !enEff)
          stateD = MODE_PON_STBY; // RL16
        else if (!stbEff && !enEff)
          stateD = MODE_STANDBY; // RL16
        else if (wakeSet || wakeQ || batteryLow)
          stateD = MODE_STANDBY; // RL17
        else if (goSleepDone)
          stateD = MODE_SLEEP; // RL16
      end
      MODE_SLEEP:
      begin
        if (stbEff && enEff)
          stateD = MODE_NORMAL;
        else if (stbEff && !enEff)
          stateD = MODE_PON_STBY;
        else if (wakeSet || batteryLow)
          stateD = MODE_STANDBY; // RL12 RL13
      end
      MODE_STANDBY:
      begin
        if (stbEff && enEff)
          stateD = MODE_NORMAL;
        else if (stbEff && !enEff)
          stateD = MODE_PON_STBY;
        else if (!stbEff && enEff && !wakeQ)
          stateD = MODE_GO_SLEEP; // RL8
      end
      default:
        stateD = RST_MODE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stateQ <= RST_MODE;
    else
      stateQ <= stateD; // RL8
  end

  // Wake flag; a new request wins over the clear by normal mode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wakeQ <= WAKE_FLAG_RST;
    else if (wakeSet)
      wakeQ <= 1'b1;
    else if (inNormal)
      wakeQ <= 1'b0;
  end

  // Power-on flag: set by power-up and by battery loss, cleared in normal
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      poFlagQ <= PON_FLAG_RST; // RL20
    else if (batteryLow)
      poFlagQ <= 1'b1; // RL20
    else if (inNormal)
      poFlagQ <= 1'b0; // RL20
  end

  // Minor failures only flag; they never touch the data path
  assign failAny = inNormal && (minorFailure || highFail || lowFail); // RL1

  // Drive only in normal, without heat or time-out; dominant is low
  assign txActive = inNormal && !overTemp && !txTimeout && !tx_data_in;

  // Registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_data_out <= 1'b1;
      fault_flag_n <= 1'b1;
      regulator_inhibit <= 1'b1;
      regulatorInhibitOe <= 1'b1;
      canHighDrive <= 1'b0;
      canLowDrive <= 1'b0;
      high_wire_termination <= 1'b1;
      low_wire_termination <= 1'b1;
      lowWireToBattery <= 1'b0;
      singleWireMode <= 1'b0;
      modeState <= RST_MODE;
    end
    else
    begin
      modeState <= stateQ;
      singleWireMode <= inNormal && (highFail || lowFail); // RL1 RL3
      // Single-wire receive on the healthy wire
      if (lowPower)
        rx_data_out <= !wakeQ; // RL9 RL11
      else if (highFail)
        rx_data_out <= !canLowDominant; // RL1
      else if (lowFail)
        rx_data_out <= !canHighDominant; // RL1
      else
        rx_data_out <= !diffDominant; // RL2
      // Fault pin meaning depends on mode
      if (inNormal)
        fault_flag_n <= !(failAny || overTemp); // RL5 RL21
      else if (stateQ == MODE_PON_STBY)
        fault_flag_n <= !poFlagQ; // RL11 RL20
      else
        fault_flag_n <= !wakeQ; // RL9
      // Inhibit floats only in sleep with battery present
      regulator_inhibit <= 1'b1;
      regulatorInhibitOe <=
        !(stateQ == MODE_SLEEP && !batteryLow); // RL9 RL10 RL13
      // Defective wire loses its output stage and termination
      canHighDrive <= txActive && !highFail; // RL4 RL21 RL23
      canLowDrive <= txActive && !lowFail; // RL4 RL21 RL23
      high_wire_termination <= !highFail; // RL4
      low_wire_termination <= !lowFail && inNormal; // RL4
      lowWireToBattery <= !lowFail && lowPower; // RL9 RL15
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_sleep_requested;
    stateQ == MODE_GO_SLEEP && !stbEff && enEff;
  endsequence

  sequence s_gosleep_expiry;
    s_sleep_requested ##0 goSleepDone && !wakeSet && !wakeQ &&
      !batteryLow;
  endsequence

  a_fault_flag_low: assert property ( // RL5
    inNormal && failAny |=> !fault_flag_n)
    else $error("fault flag not low during failure");

  a_sleep_inh_float: assert property ( // RL9
    stateQ == MODE_SLEEP && !batteryLow |=> !regulatorInhibitOe)
    else $error("inhibit driven in sleep");

  a_standby_inh_high: assert property ( // RL10
    stateQ == MODE_STANDBY |=> regulatorInhibitOe && regulator_inhibit)
    else $error("inhibit not high in standby");

  a_pon_flag_shown: assert property ( // RL11
    stateQ == MODE_PON_STBY |=> fault_flag_n == !$past(poFlagQ))
    else $error("power-on flag not on fault pin");

  a_wake_inh_on: assert property ( // RL12
    stateQ == MODE_SLEEP && wakeSet && !stbEff |-> ##2 regulatorInhibitOe)
    else $error("wake did not raise inhibit");

  a_gosleep_ends: assert property ( // RL16
    s_gosleep_expiry |=> stateQ == MODE_SLEEP)
    else $error("go-to-sleep did not end in sleep");

  a_wake_beats_sleep: assert property ( // RL17
    s_sleep_requested ##0 wakeSet |=> stateQ == MODE_STANDBY ##1
      regulatorInhibitOe)
    else $error("wake lost during go-to-sleep");

  a_supply_fail_safe: assert property ( // RL18
    logicSupplyLow |=> stateQ != MODE_NORMAL)
    else $error("normal mode with logic supply low");

  a_normal_clears_pon: assert property ( // RL20
    inNormal && !batteryLow |=> !poFlagQ)
    else $error("power-on flag kept in normal");

  a_thermal_off: assert property ( // RL21
    overTemp |=> !canHighDrive && !canLowDrive)
    else $error("drivers on during over-temperature");

  a_tx_timeout: assert property ( // RL23
    txTimeout |=> !canHighDrive && !canLowDrive)
    else $error("drivers on after dominant time-out");

  a_high_wire_off: assert property ( // RL4
    highFail |=> !canHighDrive && !high_wire_termination)
    else $error("faulty high wire still active");

endmodule : fault_tolerant_can_mode_control

// File: design/ft_can_pkg.sv
// Shared constants, types and timing counts for the CAN mode control block
package ft_can_pkg;

  // Counter width used by every timer in the block
  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] cnt_t;

  // Operating and low-power modes, one-hot
  typedef enum logic [4:0] {
    MODE_NORMAL   = 5'h01,
    MODE_PON_STBY = 5'h02,
    MODE_GO_SLEEP = 5'h04,
    MODE_SLEEP    = 5'h08,
    MODE_STANDBY  = 5'h10
  } mode_t;

  // Reset values
  localparam mode_t RST_MODE = MODE_STANDBY;
  localparam logic PON_FLAG_RST = 1'b1;
  localparam logic WAKE_FLAG_RST = 1'b0;

  // Clock period
  localparam int CLK_PERIOD_NS = 20;

  // Wake input debounce, least time, rounded up
  localparam int WAKE_DEBOUNCE_NS = 7000;
  localparam cnt_t WAKE_DEBOUNCE_CYC =
    cnt_t'((WAKE_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Transmit dominant time-out, least time, rounded up
  localparam int TX_TIMEOUT_NS = 750000;
  localparam cnt_t TX_TIMEOUT_CYC_DEF =
    cnt_t'((TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Go-to-sleep inhibit hold, longest time, rounded down
  localparam int GO_SLEEP_NS = 50000;
  localparam cnt_t GO_SLEEP_CYC = cnt_t'(GO_SLEEP_NS / CLK_PERIOD_NS);

  // Persistence delay before entering or leaving single-wire mode
  localparam int FAIL_DELAY_NS = 20000;
  localparam cnt_t FAIL_DELAY_CYC =
    cnt_t'((FAIL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Remote wake: five dominant bits at the bus bit time
  localparam int BUS_BIT_NS = 8000;
  localparam int REMOTE_WAKE_BITS = 5;
  localparam cnt_t REMOTE_WAKE_CYC = cnt_t'(
    (REMOTE_WAKE_BITS * BUS_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : ft_can_pkg

// File: design/level_filter.sv
// Persistence filter: output follows input after LIMIT stable cycles
`timescale 1ns/1ps
module level_filter #(
  parameter ft_can_pkg::cnt_t LIMIT = ft_can_pkg::FAIL_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rawIn,
  output logic filtOut,
  output logic edgePulse
);
  import ft_can_pkg::*;

  cnt_t cntQ;
  logic levelQ;
  logic armedQ;
  logic edgeQ;

  // First settle only arms the filter, so a level present at reset
  // is not mistaken for an edge
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cntQ <= '0;
      levelQ <= 1'b0;
      armedQ <= 1'b0;
      edgeQ <= 1'b0;
    end
    else
    begin
      edgeQ <= 1'b0;
      if (rawIn == levelQ && armedQ)
        cntQ <= '0;
      else if (cntQ == cnt_t'(LIMIT - cnt_t'(1)))
      begin
        cntQ <= '0;
        levelQ <= rawIn;
        armedQ <= 1'b1;
        edgeQ <= armedQ && (rawIn != levelQ);
      end
      else
        cntQ <= cnt_t'(cntQ + cnt_t'(1));
    end
  end

  assign filtOut = levelQ;
  assign edgePulse = edgeQ;

endmodule : level_filter

// File: design/dominant_timer.sv
// Hold timer: flags once the input has stayed asserted LIMIT cycles
`timescale 1ns/1ps
module dominant_timer #(
  parameter ft_can_pkg::cnt_t LIMIT = ft_can_pkg::REMOTE_WAKE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic holdIn,
  output logic expired
);
  import ft_can_pkg::*;

  cnt_t cntQ;
  logic expiredQ;

  // Count while held; any release restarts and clears the flag
  always_ff @(posedge sys_clk)
  begin
    if (rst || !holdIn)
    begin
      cntQ <= '0;
      expiredQ <= 1'b0;
    end
    else if (cntQ == cnt_t'(LIMIT - cnt_t'(1)))
      expiredQ <= 1'b1;
    else
      cntQ <= cnt_t'(cntQ + cnt_t'(1));
  end

  assign expired = expiredQ;

endmodule : dominant_timer

// File: testbench/host_model.sv
// Host controller model: mode pins and transmit data
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic [1:0] modeReq,
  input wire logic txReq,
  output logic standby_n,
  output logic enable,
  output logic tx_data_in
);
  logic [1:0] modeQ;
  logic txQ;
  // Requests taken on the rising edge, so pins never race the bench
  always @(posedge sys_clk)
  begin
    modeQ <= modeReq;
    txQ <= txReq;
  end
  // Pins move on the falling edge and stand far beyond the hold time
  always @(negedge sys_clk)
  begin
    standby_n <= modeQ[1];
    enable <= modeQ[0];
    tx_data_in <= txQ;
  end
  // Pins start low: device stays in a low-power mode after power-up
  initial
  begin
    modeQ = 2'b00;
    txQ = 1'b1;
    standby_n = 1'b0;
    enable = 1'b0;
    tx_data_in = 1'b1;
  end
endmodule : host_model

// File: testbench/testbench.sv
// Self-checking bench for the CAN mode control block
`timescale 1ns/1ps
module testbench;
  import ft_can_pkg::*;
  localparam logic [1:0] NORM = 2'b11;
  localparam logic [1:0] PON = 2'b10;
  localparam logic [1:0] GOSL = 2'b01;
  localparam int TXLIM = 40;
  logic sys_clk, rst, standby_n, enable, tx_data_in, txReq;
  logic [1:0] modeReq;
  logic wakeInput, canLowDominant, highWireFailure, lowWireFailure;
  logic canHighDominant, diffDominant, minorFailure;
  logic logicSupplyLow, batteryLow, overTemp;
  logic rx_data_out, fault_flag_n, regulator_inhibit, regulatorInhibitOe;
  logic canHighDrive, canLowDrive, singleWireMode, lowWireToBattery;
  logic high_wire_termination, low_wire_termination;
  mode_t modeState;
  int numErrors, numChecks, cycles;

  host_model host_u (.sys_clk(sys_clk), .modeReq(modeReq), .txReq(txReq),
    .standby_n(standby_n), .enable(enable), .tx_data_in(tx_data_in));

  // Short transmit time-out keeps the run brief
  fault_tolerant_can_mode_control #(.TX_TIMEOUT_CYC(cnt_t'(TXLIM))) dut_u (
    .sys_clk(sys_clk), .rst(rst), .standby_n(standby_n), .enable(enable),
    .tx_data_in(tx_data_in), .wakeInput(wakeInput),
    .canHighDominant(canHighDominant), .canLowDominant(canLowDominant),
    .diffDominant(diffDominant), .minorFailure(minorFailure),
    .highWireFailure(highWireFailure), .lowWireFailure(lowWireFailure),
    .logicSupplyLow(logicSupplyLow), .batteryLow(batteryLow),
    .overTemp(overTemp), .rx_data_out(rx_data_out),
    .fault_flag_n(fault_flag_n), .regulator_inhibit(regulator_inhibit),
    .regulatorInhibitOe(regulatorInhibitOe), .canHighDrive(canHighDrive),
    .canLowDrive(canLowDrive),
    .high_wire_termination(high_wire_termination),
    .low_wire_termination(low_wire_termination),
    .lowWireToBattery(lowWireToBattery), .singleWireMode(singleWireMode),
    .modeState(modeState));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Pin change needs two edges plus the host's own edge
  task automatic set_mode(input logic [1:0] m, input mode_t exp);
    modeReq = m;
    cyc(5);
    check("modeState", 8'(modeState), 8'(exp));
  endtask : set_mode

  task automatic t_power_on();
    check("inhibitOe", regulatorInhibitOe, 1);
    check("inh level", regulator_inhibit, 1);
    set_mode(PON, MODE_PON_STBY);
    check("pon fault", fault_flag_n, 0);
    check("pon rx", rx_data_out, 1);
    set_mode(NORM, MODE_NORMAL);
    set_mode(PON, MODE_PON_STBY);
    check("flag cleared", fault_flag_n, 1);
    set_mode(NORM, MODE_NORMAL);
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_transmit();
    txReq = 1'b0;
    cyc(5);
    check("drive high", canHighDrive, 1);
    check("drive low", canLowDrive, 1);
    cyc(TXLIM + 5);
    check("timeout", {canHighDrive, canLowDrive}, 0);
    txReq = 1'b1;
    cyc(5);
    txReq = 1'b0;
    overTemp = 1'b1;
    cyc(5);
    check("hot drive", canHighDrive, 0);
    check("hot fault", fault_flag_n, 0);
    overTemp = 1'b0;
    txReq = 1'b1;
    cyc(5);
    check("cool fault", fault_flag_n, 1);
    $display("test transmit done");
  endtask : t_transmit

  task automatic t_failure();
    highWireFailure = 1'b1;
    cyc(980);
    check("early single", singleWireMode, 0);
    cyc(40);
    check("single", singleWireMode, 1);
    check("high term", high_wire_termination, 0);
    check("low term", low_wire_termination, 1);
    check("fault", fault_flag_n, 0);
    txReq = 1'b0;
    cyc(5);
    check("dead wire", {canHighDrive, canLowDrive}, 1);
    txReq = 1'b1;
    highWireFailure = 1'b0;
    cyc(980);
    check("late diff", singleWireMode, 1);
    cyc(40);
    check("diff", singleWireMode, 0);
    check("recovered", fault_flag_n, 1);
    $display("test failure done");
  endtask : t_failure

  // Minor failure only flags; low wire failure moves to the high wire
  task automatic t_low_wire();
    minorFailure = 1'b1;
    diffDominant = 1'b1;
    cyc(5);
    check("minor fault", fault_flag_n, 0);
    check("minor rx", rx_data_out, 0);
    check("minor single", singleWireMode, 0);
    minorFailure = 1'b0;
    diffDominant = 1'b0;
    lowWireFailure = 1'b1;
    cyc(1020);
    check("low single", singleWireMode, 1);
    check("low term off", low_wire_termination, 0);
    txReq = 1'b0;
    canHighDominant = 1'b1;
    cyc(5);
    check("low dead", {canHighDrive, canLowDrive}, 2);
    check("high rx", rx_data_out, 0);
    txReq = 1'b1;
    canHighDominant = 1'b0;
    lowWireFailure = 1'b0;
    cyc(1020);
    check("low term on", low_wire_termination, 1);
    check("low fixed", fault_flag_n, 1);
    $display("test low_wire done");
  endtask : t_low_wire

  task automatic t_sleep_wake();
    set_mode(GOSL, MODE_GO_SLEEP);
    wakeInput = ~wakeInput;
    cyc(400);
    check("wake wins", 8'(modeState), 8'(MODE_STANDBY));
    check("inh kept", regulatorInhibitOe, 1);
    check("wake rx", rx_data_out, 0);
    set_mode(NORM, MODE_NORMAL);
    set_mode(GOSL, MODE_GO_SLEEP);
    cyc(2400);
    check("hold inh", regulatorInhibitOe, 1);
    cyc(120);
    check("asleep", 8'(modeState), 8'(MODE_SLEEP));
    check("inh float", regulatorInhibitOe, 0);
    check("low bias", lowWireToBattery, 1);
    check("no wake", fault_flag_n, 1);
    canLowDominant = 1'b1;
    cyc(1950);
    check("short dom", 8'(modeState), 8'(MODE_SLEEP));
    cyc(60);
    check("remote", 8'(modeState), 8'(MODE_STANDBY));
    check("wake inh", regulatorInhibitOe, 1);
    check("wake flag", fault_flag_n, 0);
    canLowDominant = 1'b0;
    set_mode(NORM, MODE_NORMAL);
    $display("test sleep_wake done");
  endtask : t_sleep_wake

  task automatic t_supplies();
    logicSupplyLow = 1'b1;
    cyc(5);
    check("vcc low", 8'(modeState), 8'(MODE_STANDBY));
    logicSupplyLow = 1'b0;
    cyc(5);
    check("vcc back", 8'(modeState), 8'(MODE_NORMAL));
    batteryLow = 1'b1;
    cyc(5);
    check("bat low", 8'(modeState), 8'(MODE_STANDBY));
    check("bat inh", regulatorInhibitOe, 1);
    // Pins reach power-on standby while still forced, else the
    // release passes through normal and clears the flag
    modeReq = PON;
    cyc(5);
    check("bat forced", 8'(modeState), 8'(MODE_STANDBY));
    batteryLow = 1'b0;
    set_mode(PON, MODE_PON_STBY);
    check("bat flag", fault_flag_n, 0);
    $display("test supplies done");
  endtask : t_supplies

  // Run limit well above the expected ten thousand cycles
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge sys_clk);
      cycles++;
      if (cycles > 30000)
      begin
        numErrors++;
        complete_run();
      end
    end
  end

  initial
  begin
    numErrors = 0;
    numChecks = 0;
    rst = 1'b1;
    modeReq = 2'b00;
    txReq = 1'b1;
    {wakeInput, canLowDominant, highWireFailure, lowWireFailure} = 4'h0;
    {canHighDominant, diffDominant, minorFailure} = 3'h0;
    {logicSupplyLow, batteryLow, overTemp} = 3'h0;
    cyc(20);
    rst = 1'b0;
    // Failure filters settle for 1000 cycles before they watch edges
    cyc(1100);
    t_power_on();
    t_transmit();
    t_failure();
    t_low_wire();
    t_sleep_wake();
    t_supplies();
    complete_run();
  end
endmodule : testbench
